// file: rtl/bgis_processor.sv
// Processor end: samples the bus request, interrupts and flag input,
// releases the memory strobes and hands the bus over.
// Assumes all link inputs may be asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
// What this block needs and does
// - Reset held low at least five clocks; not measured, reset_held_ok only counts clocks after release.
// - Clock loop settles within 2000 input clocks.
// - Interrupt or flag seen by the core on the third clock edge after the input changes.
// - Edge interrupt pulses longer than 10 ns; sampled on clk only, so a pulse shorter than one 25 ns cycle can be missed.
// - Level interrupts stay low until serviced.
// - Bus request recognised on the third clock edge after it falls.
// - Grant asserts the cycle after recognition.
// - Asynchronous bus request needs no outside synchroniser.
// - Bus request pulses longer than 10 ns; sampled on clk only, so a pulse shorter than one 25 ns cycle can be missed.
module bgis_processor (
  input wire logic clk, // System clock, also the input clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  bgis_link_if.processor link, // Link to the outside requester.
  input wire logic core_dms_n, // Core data memory select.
  input wire logic core_pms_n, // Core program memory select.
  input wire logic core_bms_n, // Core boot memory select.
  input wire logic core_rd_n, // Core read strobe.
  input wire logic core_wr_n, // Core write strobe.
  input wire logic core_flag_out, // Core flag output value.
  input wire logic [bgis_pkg::NUM_IRQ-1:0] irq_edge_mode, // One selects edge sense.
  input wire logic [bgis_pkg::NUM_IRQ-1:0] irq_serviced, // Pulse clears a latched edge.
  output logic [bgis_pkg::NUM_IRQ-1:0] irq_pending, // Interrupts seen by the core.
  output logic flag_seen, // Sampled flag input.
  output logic core_stalled, // Core has lost the bus.
  output logic pll_locked, // Clock loop has settled.
  output logic reset_held_ok // Minimum count has run since reset release.
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Two stages make the asynchronous request safe; the first stage is
  // read only by the second.
  localparam int SYNC_W = bgis_pkg::NUM_IRQ + 2;
  // Idle levels: request and interrupts high, flag input low, so no false event follows reset.
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b1, 1'b0, {bgis_pkg::NUM_IRQ{1'b1}}};
  logic [SYNC_W-1:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;

  always_comb begin
    nxt_sync1 = {link.bus_request_n, link.flag_input, link.interrupt_request_n};
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= SYNC_IDLE;
      sync2_ff <= SYNC_IDLE;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  logic req_seen;
  logic [bgis_pkg::NUM_IRQ-1:0] irq_lvl;
  assign req_seen = ~sync2_ff[SYNC_W-1];
  assign irq_lvl = ~sync2_ff[bgis_pkg::NUM_IRQ-1:0];

  // ----------------------------------------------------------------
  // Interrupt and flag recognition
  // ----------------------------------------------------------------
  // A latched set is used for edge mode so a sampled edge is held until serviced;
  // a set in the same cycle as a service wins over the clear.
  logic [bgis_pkg::NUM_IRQ-1:0] irq_prev_ff, nxt_irq_prev;
  logic [bgis_pkg::NUM_IRQ-1:0] irq_latch_ff, nxt_irq_latch;
  logic flag_ff, nxt_flag;

  genvar gi;
  generate
    for (gi = 0; gi < bgis_pkg::NUM_IRQ; gi++) begin : g_irq
      always_comb begin
        nxt_irq_prev[gi] = irq_lvl[gi];
        if (irq_lvl[gi] & ~irq_prev_ff[gi]) begin
          nxt_irq_latch[gi] = 1'b1;
        end else if (irq_serviced[gi]) begin
          nxt_irq_latch[gi] = 1'b0;
        end else begin
          nxt_irq_latch[gi] = irq_latch_ff[gi];
        end
      end
      // Level mode follows the line, which the source holds until serviced.
      assign irq_pending[gi] = irq_edge_mode[gi] ? irq_latch_ff[gi] : irq_prev_ff[gi];
    end
  endgenerate

  always_comb begin
    nxt_flag = sync2_ff[bgis_pkg::NUM_IRQ];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_prev_ff <= '0;
      irq_latch_ff <= '0;
      flag_ff <= 1'b0;
    end else begin
      irq_prev_ff <= nxt_irq_prev;
      irq_latch_ff <= nxt_irq_latch;
      flag_ff <= nxt_flag;
    end
  end
  assign flag_seen = flag_ff;

  // ----------------------------------------------------------------
  // Bus arbitration
  // ----------------------------------------------------------------
  bgis_pkg::bgis_state_t state_ff, nxt_state;
  logic grant_n_ff, nxt_grant_n;
  logic oe_ff, nxt_oe;

  // Recognition floats the strobes; grant follows one cycle later, so the
  // strobes are off before the grant falls.
  always_comb begin
    nxt_state = state_ff;
    nxt_grant_n = grant_n_ff;
    nxt_oe = oe_ff;
    case (state_ff)
      bgis_pkg::BGIS_OWN: begin
        if (req_seen && pll_locked) begin
          nxt_state = bgis_pkg::BGIS_RELEASE;
          nxt_oe = 1'b0;
        end
      end
      bgis_pkg::BGIS_RELEASE: begin
        nxt_state = bgis_pkg::BGIS_GRANTED;
        nxt_grant_n = 1'b0;
      end
      bgis_pkg::BGIS_GRANTED: begin
        if (!req_seen) begin
          nxt_state = bgis_pkg::BGIS_RESUME;
          nxt_grant_n = 1'b1;
        end
      end
      bgis_pkg::BGIS_RESUME: begin
        nxt_state = bgis_pkg::BGIS_OWN;
        nxt_oe = 1'b1;
      end
      default: begin
        nxt_state = bgis_pkg::BGIS_OWN;
        nxt_grant_n = 1'b1;
        nxt_oe = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= bgis_pkg::BGIS_OWN;
      grant_n_ff <= 1'b1;
      oe_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      grant_n_ff <= nxt_grant_n;
      oe_ff <= nxt_oe;
    end
  end

  // ----------------------------------------------------------------
  // Start-up counters
  // ----------------------------------------------------------------
  // The loop settle time is modelled as a fixed count; arbitration waits
  // for it so no grant is given on an unstable clock.
  logic [bgis_pkg::PLL_CNT_W-1:0] pll_cnt_ff, nxt_pll_cnt;
  logic lock_ff, nxt_lock;
  logic [bgis_pkg::RST_CNT_W-1:0] rst_cnt_ff, nxt_rst_cnt;
  logic rst_ok_ff, nxt_rst_ok;

  always_comb begin
    nxt_pll_cnt = pll_cnt_ff;
    nxt_lock = lock_ff;
    if (!lock_ff) begin
      if (pll_cnt_ff == bgis_pkg::PLL_CNT_W'(bgis_pkg::PLL_SETTLE_CLKS - 1)) begin
        nxt_lock = 1'b1;
      end else begin
        nxt_pll_cnt = pll_cnt_ff + 1'b1;
      end
    end
    // A reset shorter than the minimum cannot be measured after the fact
    // with an async reset, so only the startup hold is checked: the flag
    // rises once the block has run the minimum count after release.
    nxt_rst_cnt = rst_cnt_ff;
    nxt_rst_ok = rst_ok_ff;
    if (rst_cnt_ff == bgis_pkg::RST_CNT_W'(bgis_pkg::RESET_MIN_CLKS)) begin
      nxt_rst_ok = 1'b1;
    end else begin
      nxt_rst_cnt = rst_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pll_cnt_ff <= '0;
      lock_ff <= 1'b0;
      rst_cnt_ff <= '0;
      rst_ok_ff <= 1'b0;
    end else begin
      pll_cnt_ff <= nxt_pll_cnt;
      lock_ff <= nxt_lock;
      rst_cnt_ff <= nxt_rst_cnt;
      rst_ok_ff <= nxt_rst_ok;
    end
  end
  assign pll_locked = lock_ff;
  assign reset_held_ok = rst_ok_ff;

  // ----------------------------------------------------------------
  // Link outputs
  // ----------------------------------------------------------------
  logic flag_out_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_out_ff <= 1'b0;
    end else begin
      flag_out_ff <= core_flag_out;
    end
  end

  assign link.bus_grant_n = grant_n_ff;
  assign link.strobe_oe = oe_ff;
  assign link.data_memory_select_n = core_dms_n;
  assign link.program_memory_select_n = core_pms_n;
  assign link.boot_memory_select_n = core_bms_n;
  assign link.read_strobe_n = core_rd_n;
  assign link.write_strobe_n = core_wr_n;
  assign link.flag_output = flag_out_ff;
  assign link.processor_clock_out = clk;
  assign core_stalled = ~oe_ff;
endmodule
`default_nettype wire

// file: rtl/bgis_pkg.sv
// Package for the bus grant and input sampling block.
// Assumes a single 40 MHz clock shared by both ends.
package bgis_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_MIN_CLKS = 5;
  localparam int PLL_SETTLE_CLKS = 2000;
  localparam int PULSE_MIN_NS = 10;
  // Least time rounds up, never below one cycle.
  localparam int PULSE_MIN_CLKS_RAW = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_MIN_CLKS = (PULSE_MIN_CLKS_RAW < 1) ? 1 : PULSE_MIN_CLKS_RAW;
  localparam int PLL_CNT_W = 11;
  localparam int RST_CNT_W = 3;
  localparam int NUM_IRQ = 3;
  // ----------------------------------------------------------------
  // Arbiter states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BGIS_OWN = 2'b00,
    BGIS_RELEASE = 2'b01,
    BGIS_GRANTED = 2'b10,
    BGIS_RESUME = 2'b11
  } bgis_state_t;
endpackage

// file: rtl/bgis_link_if.sv
// Interface joining the processor end and the outside requester end.
// Assumes the testbench resolves the shared strobe wires from the enables.
`timescale 1ns/1ps
`default_nettype none
interface bgis_link_if;
  logic bus_request_n;
  logic bus_grant_n;
  logic [bgis_pkg::NUM_IRQ-1:0] interrupt_request_n;
  logic flag_input;
  logic flag_output;
  logic data_memory_select_n;
  logic program_memory_select_n;
  logic boot_memory_select_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic strobe_oe;
  logic ext_strobe_oe;
  logic ext_data_memory_select_n;
  logic ext_read_strobe_n;
  logic ext_write_strobe_n;
  logic processor_clock_out;

  modport processor (
    input bus_request_n, interrupt_request_n, flag_input,
    output bus_grant_n, flag_output, data_memory_select_n, program_memory_select_n,
    output boot_memory_select_n, read_strobe_n, write_strobe_n, strobe_oe,
    output processor_clock_out
  );
  modport requester (
    output bus_request_n, interrupt_request_n, flag_input,
    output ext_strobe_oe, ext_data_memory_select_n, ext_read_strobe_n, ext_write_strobe_n,
    input bus_grant_n, flag_output, processor_clock_out
  );
endinterface
`default_nettype wire

// file: rtl/bgis_requester.sv
// Outside requester end: asks for the bus, drives strobes while granted,
// and drives interrupt and flag inputs of the processor.
// Assumes the user side holds its requests as levels.
`timescale 1ns/1ps
`default_nettype none
module bgis_requester (
  input wire logic clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  bgis_link_if.requester link, // Link to the processor.
  input wire logic want_bus, // User asks for the bus.
  input wire logic ext_dms_n, // Data select to drive while owning.
  input wire logic ext_rd_n, // Read strobe to drive while owning.
  input wire logic ext_wr_n, // Write strobe to drive while owning.
  input wire logic [bgis_pkg::NUM_IRQ-1:0] irq_drive_n, // Interrupt levels.
  input wire logic flag_drive, // Flag level to present.
  output logic have_bus // Bus is owned by this end.
);
  // ----------------------------------------------------------------
  // Request and ownership
  // ----------------------------------------------------------------
  logic req_n_ff, nxt_req_n;
  logic own_ff, nxt_own;
  logic [bgis_pkg::NUM_IRQ-1:0] irq_ff, nxt_irq;
  logic flag_ff, nxt_flag;

  // Request is held as a registered level, so pulses last whole cycles.
  // Interrupt lines are registered levels the user keeps until serviced.
  always_comb begin
    nxt_req_n = ~want_bus;
    nxt_own = ~link.bus_grant_n & ~req_n_ff;
    nxt_irq = irq_drive_n;
    nxt_flag = flag_drive;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_n_ff <= 1'b1;
      own_ff <= 1'b0;
      irq_ff <= {bgis_pkg::NUM_IRQ{1'b1}};
      flag_ff <= 1'b0;
    end else begin
      req_n_ff <= nxt_req_n;
      own_ff <= nxt_own;
      irq_ff <= nxt_irq;
      flag_ff <= nxt_flag;
    end
  end

  // Strobes are driven only while the grant is still low and we still ask;
  // dropping the request stops them at once, ahead of the grant rising.
  assign link.bus_request_n = req_n_ff;
  assign link.interrupt_request_n = irq_ff;
  assign link.flag_input = flag_ff;
  assign link.ext_strobe_oe = own_ff & ~link.bus_grant_n & ~req_n_ff;
  assign link.ext_data_memory_select_n = ext_dms_n;
  assign link.ext_read_strobe_n = ext_rd_n;
  assign link.ext_write_strobe_n = ext_wr_n;
  assign have_bus = own_ff;
endmodule
`default_nettype wire

// file: testbench/bgis_link_chk.sv
// Checker for the bus handover seen on the link between both ends.
// Assumes one clock and the link signals handed in as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module bgis_link_chk (
  input wire logic clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic bus_request_n, // Request from the outside end.
  input wire logic bus_grant_n, // Grant from the processor end.
  input wire logic strobe_oe // High while the processor drives strobes.
);
  localparam int LOCK_CLKS = 2000;
  logic [11:0] up_ff;
  // ------
  // Helper
  // ------
  // Cycles since release; it saturates so a long run never wraps.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) up_ff <= 12'h000;
    else if (up_ff != 12'hFFF) up_ff <= up_ff + 12'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ------
  // Checks
  // ------
  a_no_early_grant: assert property (!bus_grant_n |-> up_ff > LOCK_CLKS)
    else $error("grant before the clock loop settled");
  a_request_seen: assert property ($fell(bus_request_n) && strobe_oe && up_ff > 12'h7E0
    |-> ##[2:4] !strobe_oe) else $error("request not taken in time");
  a_grant_next: assert property ($fell(strobe_oe) |-> ##1 $fell(bus_grant_n))
    else $error("grant not one cycle after recognition");
  a_float_in_grant: assert property (!bus_grant_n |-> !strobe_oe)
    else $error("strobes driven during grant");
  a_drive_after: assert property ($rose(strobe_oe) |-> bus_grant_n && $past(bus_grant_n))
    else $error("strobes driven before grant went high");
  a_grant_holds: assert property (!bus_grant_n && !bus_request_n |=> !bus_grant_n)
    else $error("grant dropped while request held");
  a_grant_release: assert property ($rose(bus_request_n) && !bus_grant_n |-> ##[1:5] bus_grant_n)
    else $error("grant not returned");
  a_oe_return: assert property ($rose(bus_grant_n) |-> ##1 strobe_oe)
    else $error("bus not resumed");
endmodule
`default_nettype wire

// file: testbench/bus_grant_and_input_sampling_tb_top.sv
// Bench joining both ends across the link interface.
// Assumes the shared select wire idles high through a pull-up.
`timescale 1ns/1ps
`default_nettype none
module bus_grant_and_input_sampling_tb_top;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic want_bus, core_strb_n, ext_strb_n, flag_drive, core_flag_out;
  logic [2:0] irq_drive_n, irq_edge_mode, irq_serviced, irq_pending;
  logic have_bus, flag_seen, core_stalled, pll_locked, reset_held_ok;
  int errors = 0;
  int compares = 0;
  wire dms_wire;
  wire [3:0] strb_wire;
  bgis_link_if link ();
  // Shared select wire: processor, else requester, else the pull-up.
  assign dms_wire = link.strobe_oe ? link.data_memory_select_n :
    (link.ext_strobe_oe ? link.ext_data_memory_select_n : 1'h1);
  // Other shared strobes; the requester has no program or boot select of its own.
  assign strb_wire = link.strobe_oe ? {link.program_memory_select_n,
    link.boot_memory_select_n, link.read_strobe_n, link.write_strobe_n} :
    (link.ext_strobe_oe ? {2'h3, link.ext_read_strobe_n, link.ext_write_strobe_n} : 4'hF);
  bgis_processor u_bgis_processor (.clk(clk), .reset_n(reset_n), .link(link.processor),
    .core_dms_n(core_strb_n), .core_pms_n(core_strb_n), .core_bms_n(core_strb_n),
    .core_rd_n(core_strb_n), .core_wr_n(core_strb_n), .core_flag_out(core_flag_out),
    .irq_edge_mode(irq_edge_mode), .irq_serviced(irq_serviced), .irq_pending(irq_pending),
    .flag_seen(flag_seen), .core_stalled(core_stalled), .pll_locked(pll_locked),
    .reset_held_ok(reset_held_ok));
  bgis_requester u_bgis_requester (.clk(clk), .reset_n(reset_n), .link(link.requester),
    .want_bus(want_bus), .ext_dms_n(ext_strb_n), .ext_rd_n(ext_strb_n),
    .ext_wr_n(ext_strb_n), .irq_drive_n(irq_drive_n), .flag_drive(flag_drive),
    .have_bus(have_bus));
  bgis_link_chk u_bgis_link_chk (.clk(clk), .reset_n(reset_n),
    .bus_request_n(link.bus_request_n), .bus_grant_n(link.bus_grant_n),
    .strobe_oe(link.strobe_oe));
  // Free-running 40 MHz clock.
  always #12.5 clk = ~clk;
  // ------
  // Helpers
  // ------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ------
  // Scenarios
  // ------
  // Asked before the loop settles: the grant must wait for lock.
  task automatic t_lock_and_grant();
    int n;
    n = 0;
    chk({link.bus_grant_n, link.strobe_oe, pll_locked, have_bus}, 4'hC);
    want_bus = 1'h1;
    while (pll_locked !== 1'h1 && n < 2100) begin
      cyc(1);
      n++;
    end
    chk(4'(n <= 2000), 4'h1);
    chk({3'h0, link.bus_grant_n}, 4'h1);
    cyc(10);
    chk({link.bus_grant_n, link.strobe_oe, have_bus, core_stalled}, 4'h3);
    chk({3'h0, dms_wire}, 4'h0);
    chk(strb_wire, 4'hC);
    $display("test lock_and_grant done");
  endtask
  // Release, then ask again and time the grant from the request edge.
  task automatic t_handover();
    int n;
    n = 0;
    want_bus = 1'h0;
    cyc(6);
    chk({link.bus_grant_n, link.strobe_oe, have_bus, dms_wire}, 4'hC);
    chk(strb_wire, 4'h0);
    want_bus = 1'h1;
    cyc(1);
    while (link.bus_grant_n !== 1'h0 && n < 20) begin
      cyc(1);
      n++;
    end
    chk(4'(n), 4'h4);
    want_bus = 1'h0;
    cyc(8);
    $display("test handover done");
  endtask
  // Each interrupt line in level then edge mode; edge mode uses one 25 ns pulse.
  task automatic t_irq();
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 3; i++) begin
        irq_edge_mode = 3'(m * 7);
        irq_drive_n[i] = 1'h0;
        cyc(1);
        if (m == 1) irq_drive_n[i] = 1'h1;
        cyc(3);
        chk({1'h0, irq_pending}, 4'(1 << i));
        irq_drive_n[i] = 1'h1;
        irq_serviced[i] = 1'h1;
        cyc(1);
        irq_serviced = 3'h0;
        cyc(4);
        chk({1'h0, irq_pending}, 4'h0);
      end
    end
    $display("test irq done");
  endtask
  // Flag input sampled in, flag output passed out.
  task automatic t_flag();
    flag_drive = 1'h1;
    core_flag_out = 1'h1;
    cyc(4);
    chk({2'h0, flag_seen, link.flag_output}, 4'h3);
    flag_drive = 1'h0;
    core_flag_out = 1'h0;
    cyc(4);
    chk({2'h0, flag_seen, link.flag_output}, 4'h0);
    // The clock output is looked at just after a rising edge, clear of the edge itself.
    @(posedge clk);
    #1;
    chk({3'h0, link.processor_clock_out}, 4'h1);
    cyc(1);
    $display("test flag done");
  endtask
  // Mid-run reset held for the minimum; the hold flag must count up again.
  task automatic t_reset_again();
    int n;
    n = 0;
    reset_n = 1'h0;
    cyc(bgis_pkg::RESET_MIN_CLKS);
    chk({link.bus_grant_n, link.strobe_oe, pll_locked, reset_held_ok}, 4'hC);
    reset_n = 1'h1;
    while (reset_held_ok !== 1'h1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk(4'(n), 4'(bgis_pkg::RESET_MIN_CLKS + 1));
    chk({3'h0, pll_locked}, 4'h0);
    $display("test reset_again done");
  endtask
  // Main sequence; inputs change on falling edges only.
  initial begin
    want_bus = 1'h0;
    core_strb_n = 1'h0;
    ext_strb_n = 1'h0;
    flag_drive = 1'h0;
    core_flag_out = 1'h0;
    irq_drive_n = 3'h7;
    irq_edge_mode = 3'h0;
    irq_serviced = 3'h0;
    // Power-up reset; the five-clock minimum only binds once power-up is over.
    cyc(3);
    reset_n = 1'h1;
    cyc(1);
    t_lock_and_grant();
    t_handover();
    t_irq();
    t_flag();
    t_reset_again();
    report_and_stop();
  end
  // Watchdog: the run needs about 2100 cycles.
  initial begin
    #(3000 * 25);
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
